// *** rtl/mcs_defines.svh ***
`ifndef MCS_DEFINES_SVH
`define MCS_DEFINES_SVH
// register offsets
`define MCS_ADDR_DEVICE_STATUS 8'h05
`define MCS_ADDR_SHAKE_THR_HIGH 8'h47
`define MCS_ADDR_PEAK_DUR_LOW 8'h48
`define MCS_ADDR_SHAKE_CNT_PEAK_HIGH 8'h49
`define MCS_ADDR_TIMER_CONTROL 8'h4a
`define MCS_ADDR_BURST_READ_COUNT 8'h4b
// reset values
`define MCS_RST_SHAKE_THR_HIGH 8'h00
`define MCS_RST_PEAK_DUR_LOW 8'h00
`define MCS_RST_SHAKE_CNT_PEAK_HIGH 8'h00
`define MCS_RST_TIMER_CONTROL 8'h00
`define MCS_RST_BURST_READ_COUNT 8'h06
// writable bits; reserved bits store nothing and read zero
`define MCS_WMASK_SHAKE_CNT_PEAK_HIGH 8'h7f
`define MCS_WMASK_TIMER_CONTROL 8'hf7
// status field positions
`define MCS_STAT_STATE_LSB 0
`define MCS_STAT_RES_BIT 2
`define MCS_STAT_WDT_BIT 4
`define MCS_STAT_OTP_BIT 7
// stall time before the bus watchdog fires, and clock period
`define MCS_STALL_TIME_NS 1000000
`define MCS_CLK_PERIOD_NS 5
`define MCS_STALL_CYCLES ((`MCS_STALL_TIME_NS + `MCS_CLK_PERIOD_NS - 1) / `MCS_CLK_PERIOD_NS)
`endif

// *** rtl/mcs_pkg.sv ***
package mcs_pkg;
   // operating state as reported in the status register
   typedef enum logic [1:0] {
      MCS_OP_STANDBY = 2'h0,
      MCS_OP_WAKE = 2'h1
   } mcs_op_state_t;
   // byte-wide register value
   typedef logic [7:0] mcs_byte_t;
endpackage

// *** rtl/mcs_watch_if.sv ***
`timescale 1ns/100ps
`default_nettype none
// link between the register bank and its serial clock stall watcher
interface mcs_watch_if;
   logic scl;       // serial clock level
   logic busy;      // target is inside a transaction
   logic low_en;    // watch low stalls
   logic high_en;   // watch high stalls
   logic timeout;   // one-cycle stall event
   modport watcher (input scl, input busy, input low_en, input high_en, output timeout);
   modport owner (output scl, output busy, output low_en, output high_en, input timeout);
endinterface
`default_nettype wire

// *** rtl/mcs_stall_watch.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "mcs_defines.svh"
module mcs_stall_watch #(
   parameter int STALL_CYCLES = `MCS_STALL_CYCLES
) (
   input wire logic ref_clk_i,       // block clock
   input wire logic reset_i,         // sync reset, active high
   mcs_watch_if.watcher watch        // stall watch signals
);
   localparam int CW = $clog2(STALL_CYCLES + 1);
   logic [CW-1:0] count_q, count_d;  // cycles the clock has stood still
   logic scl_q, scl_d;               // last clock level
   logic armed;                      // watching the present level
   logic fire;                       // limit reached this cycle

   // a stall only counts for the level whose watch is enabled
   always_comb begin
      armed = watch.busy && (watch.scl ? watch.high_en : watch.low_en);
      fire = armed && (count_q == CW'(STALL_CYCLES - 1));
      scl_d = watch.scl;
      if (!armed || (watch.scl != scl_q) || fire) begin
         count_d = '0;  // restart on edge, disable or event
      end else begin
         count_d = count_q + CW'(1);
      end
   end

   // count and last clock level registers
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         count_q <= '0;
         scl_q <= 1'b1;
      end else begin
         count_q <= count_d;
         scl_q <= scl_d;
      end
   end

   assign watch.timeout = fire;

   // disabled watch never accumulates a stall
   property p_watch_off_idle;
      @(posedge ref_clk_i) disable iff (reset_i)
         (!watch.low_en && !watch.high_en) |=> (count_q == '0);
   endproperty
   a_watch_off_idle: assert property (p_watch_off_idle) else $error("stall count ran while watch off");

   // an event only fires on an enabled level
   property p_fire_enabled;
      @(posedge ref_clk_i) disable iff (reset_i)
         watch.timeout |-> (watch.scl ? watch.high_en : watch.low_en);
   endproperty
   a_fire_enabled: assert property (p_fire_enabled) else $error("stall event on disabled level");
endmodule
`default_nettype wire

// *** rtl/motion_config_status_regs.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "mcs_defines.svh"
module motion_config_status_regs #(
   parameter int STALL_CYCLES = `MCS_STALL_CYCLES  // bus stall limit in clocks
) (
   input wire logic ref_clk_i,                    // block clock, 200 MHz
   input wire logic reset_i,                      // sync reset, active high
   input wire logic [7:0] reg_addr_i,             // register address from serial target
   input wire logic reg_wr_i,                     // write strobe, one cycle
   input wire logic reg_rd_i,                     // read strobe, one cycle
   input wire logic [7:0] reg_wdata_i,            // write data
   output logic [7:0] reg_rdata_o,                // read data, registered
   input wire logic [1:0] op_state_i,             // operating state from mode logic
   input wire logic otp_active_i,                 // one-time memory is working
   input wire logic scl_i,                        // serial clock level
   input wire logic bus_busy_i,                   // serial target in a transaction
   input wire logic low_stall_watch_enable_i,     // watch low clock stalls
   input wire logic high_stall_watch_enable_i,    // watch high clock stalls
   output logic target_idle_o,                    // pulse: return target to idle
   output logic bus_watchdog_timeout_flag_o,      // sticky stall flag
   output logic [7:0] shake_level_high_o,         // shake threshold upper byte
   output logic [11:0] peak_span_duration_o,      // peak-to-peak duration
   output logic [2:0] shake_count_window_o,       // shake duration count
   output logic temp_period_int_en_o,             // periodic timer interrupt enable
   output logic [2:0] temp_period_o,              // periodic timer period
   output logic [2:0] tilt35_timer_o,             // tilt-35 duration
   output logic [7:0] burst_read_count_o          // burst read count
);
   mcs_watch_if watch_link ();                     // link to the stall watcher

   // stored configuration bytes
   mcs_pkg::mcs_byte_t shk_hi_q, shk_hi_d;        // shake threshold high
   mcs_pkg::mcs_byte_t pk_lo_q, pk_lo_d;          // peak duration low
   mcs_pkg::mcs_byte_t pk_hi_q, pk_hi_d;          // shake count and peak high
   mcs_pkg::mcs_byte_t tmr_q, tmr_d;              // timer control
   mcs_pkg::mcs_byte_t rdcnt_q, rdcnt_d;          // burst read count
   // status and read path
   logic wdt_flag_q, wdt_flag_d;                  // watchdog timeout flag
   mcs_pkg::mcs_byte_t rdata_q, rdata_d;          // read data holding register
   mcs_pkg::mcs_byte_t status_now;                // live status byte
   mcs_pkg::mcs_op_state_t state_rep;             // reported state
   logic status_read;                             // status register read this cycle

   // writable bit mask per address, zero for read-only or unmapped
   function automatic mcs_pkg::mcs_byte_t wmask(input logic [7:0] addr);
      case (addr)
         `MCS_ADDR_SHAKE_THR_HIGH: wmask = 8'hff;
         `MCS_ADDR_PEAK_DUR_LOW: wmask = 8'hff;
         `MCS_ADDR_SHAKE_CNT_PEAK_HIGH: wmask = `MCS_WMASK_SHAKE_CNT_PEAK_HIGH;
         `MCS_ADDR_TIMER_CONTROL: wmask = `MCS_WMASK_TIMER_CONTROL;
         `MCS_ADDR_BURST_READ_COUNT: wmask = 8'hff;
         default: wmask = 8'h00;
      endcase
   endfunction

   // write helper: take the masked new value when addressed
   function automatic mcs_pkg::mcs_byte_t wr_byte(input mcs_pkg::mcs_byte_t cur, input logic [7:0] here,
                                                 input logic wr, input logic [7:0] addr,
                                                 input mcs_pkg::mcs_byte_t wd);
      if (wr && (addr == here)) begin
         wr_byte = wd & wmask(addr);
      end else begin
         wr_byte = cur;
      end
   endfunction

   // stall watcher hookup
   assign watch_link.scl = scl_i;
   assign watch_link.busy = bus_busy_i;
   assign watch_link.low_en = low_stall_watch_enable_i;
   assign watch_link.high_en = high_stall_watch_enable_i;

   mcs_stall_watch #(
      .STALL_CYCLES(STALL_CYCLES)
   ) u_watch (
      .ref_clk_i(ref_clk_i),
      .reset_i(reset_i),
      .watch(watch_link.watcher)
   );

   // configuration register next values
   always_comb begin
      // only listed read-write addresses store; status and others ignore writes
      shk_hi_d = wr_byte(shk_hi_q, `MCS_ADDR_SHAKE_THR_HIGH, reg_wr_i, reg_addr_i, reg_wdata_i);
      pk_lo_d = wr_byte(pk_lo_q, `MCS_ADDR_PEAK_DUR_LOW, reg_wr_i, reg_addr_i, reg_wdata_i);
      pk_hi_d = wr_byte(pk_hi_q, `MCS_ADDR_SHAKE_CNT_PEAK_HIGH, reg_wr_i, reg_addr_i, reg_wdata_i);
      tmr_d = wr_byte(tmr_q, `MCS_ADDR_TIMER_CONTROL, reg_wr_i, reg_addr_i, reg_wdata_i);
      rdcnt_d = wr_byte(rdcnt_q, `MCS_ADDR_BURST_READ_COUNT, reg_wr_i, reg_addr_i, reg_wdata_i);
   end

   // configuration registers
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         shk_hi_q <= `MCS_RST_SHAKE_THR_HIGH;
         pk_lo_q <= `MCS_RST_PEAK_DUR_LOW;
         pk_hi_q <= `MCS_RST_SHAKE_CNT_PEAK_HIGH;
         tmr_q <= `MCS_RST_TIMER_CONTROL;
         rdcnt_q <= `MCS_RST_BURST_READ_COUNT;
      end else begin
         shk_hi_q <= shk_hi_d;
         pk_lo_q <= pk_lo_d;
         pk_hi_q <= pk_hi_d;
         tmr_q <= tmr_d;
         rdcnt_q <= rdcnt_d;
      end
   end

   // status byte and read mux
   always_comb begin
      status_read = reg_rd_i && (reg_addr_i == `MCS_ADDR_DEVICE_STATUS);
      // any state other than wake is shown as standby, so reserved codes never appear
      if (op_state_i == 2'h1) begin
         state_rep = mcs_pkg::MCS_OP_WAKE;
      end else begin
         state_rep = mcs_pkg::MCS_OP_STANDBY;
      end
      status_now = 8'h00;
      status_now[`MCS_STAT_STATE_LSB +: 2] = state_rep;
      status_now[`MCS_STAT_RES_BIT] = 1'b0;
      status_now[`MCS_STAT_WDT_BIT] = wdt_flag_q;
      status_now[`MCS_STAT_OTP_BIT] = otp_active_i;
      // set beats the read clear, so an event landing on the read is kept
      if (watch_link.timeout) begin
         wdt_flag_d = 1'b1;
      end else if (status_read) begin
         wdt_flag_d = 1'b0;
      end else begin
         wdt_flag_d = wdt_flag_q;
      end
      rdata_d = rdata_q;
      if (reg_rd_i) begin
         case (reg_addr_i)
            `MCS_ADDR_DEVICE_STATUS: rdata_d = status_now;
            `MCS_ADDR_SHAKE_THR_HIGH: rdata_d = shk_hi_q;
            `MCS_ADDR_PEAK_DUR_LOW: rdata_d = pk_lo_q;
            `MCS_ADDR_SHAKE_CNT_PEAK_HIGH: rdata_d = pk_hi_q;
            `MCS_ADDR_TIMER_CONTROL: rdata_d = tmr_q;
            `MCS_ADDR_BURST_READ_COUNT: rdata_d = rdcnt_q;
            default: rdata_d = 8'h00;  // unmapped or reserved reads zero
         endcase
      end
   end

   // status and read registers
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         wdt_flag_q <= 1'b0;
         rdata_q <= 8'h00;
      end else begin
         wdt_flag_q <= wdt_flag_d;
         rdata_q <= rdata_d;
      end
   end

   // outputs
   assign reg_rdata_o = rdata_q;
   assign target_idle_o = watch_link.timeout;
   assign bus_watchdog_timeout_flag_o = wdt_flag_q;
   assign shake_level_high_o = shk_hi_q;
   assign peak_span_duration_o = {pk_hi_q[3:0], pk_lo_q};
   assign shake_count_window_o = pk_hi_q[6:4];
   assign temp_period_int_en_o = tmr_q[7];
   assign temp_period_o = tmr_q[6:4];
   assign tilt35_timer_o = tmr_q[2:0];
   assign burst_read_count_o = rdcnt_q;

   // status read shows wake only for wake, standby otherwise
   property p_state_report;
      @(posedge ref_clk_i) disable iff (reset_i)
         status_read |=> (reg_rdata_o[1:0] == (($past(op_state_i) == 2'h1) ? 2'h1 : 2'h0));
   endproperty
   a_state_report: assert property (p_state_report) else $error("status state field wrong");

   // resolution bit is always zero on status reads
   property p_res_zero;
      @(posedge ref_clk_i) disable iff (reset_i)
         status_read |=> !reg_rdata_o[2];
   endproperty
   a_res_zero: assert property (p_res_zero) else $error("resolution bit not zero");

   // stall event idles target and raises the flag next cycle
   property p_wdt_set;
      @(posedge ref_clk_i) disable iff (reset_i)
         watch_link.timeout |-> target_idle_o ##1 bus_watchdog_timeout_flag_o;
   endproperty
   a_wdt_set: assert property (p_wdt_set) else $error("watchdog event not flagged");

   // status read returns the flag then clears it
   property p_wdt_clear;
      @(posedge ref_clk_i) disable iff (reset_i)
         (status_read && !watch_link.timeout) |=> (!bus_watchdog_timeout_flag_o
            && (reg_rdata_o[4] == $past(bus_watchdog_timeout_flag_o)));
   endproperty
   a_wdt_clear: assert property (p_wdt_clear) else $error("status read did not clear flag");

   // busy bit tracks memory activity at read time
   property p_otp_busy;
      @(posedge ref_clk_i) disable iff (reset_i)
         status_read |=> (reg_rdata_o[7] == $past(otp_active_i));
   endproperty
   a_otp_busy: assert property (p_otp_busy) else $error("busy bit mismatch");

   // writes to read-only or unmapped addresses change nothing
   property p_ro_ignore;
      @(posedge ref_clk_i) disable iff (reset_i)
         (reg_wr_i && (wmask(reg_addr_i) == 8'h00)) |=> ($stable(shk_hi_q) && $stable(pk_lo_q)
            && $stable(pk_hi_q) && $stable(tmr_q) && $stable(rdcnt_q));
   endproperty
   a_ro_ignore: assert property (p_ro_ignore) else $error("write to read-only changed state");

   // read-write register written then read returns the masked value
   property p_rw_back;
      @(posedge ref_clk_i) disable iff (reset_i)
         (reg_wr_i && (reg_addr_i == `MCS_ADDR_TIMER_CONTROL)) ##1
            (reg_rd_i && !reg_wr_i && (reg_addr_i == `MCS_ADDR_TIMER_CONTROL))
            |=> (reg_rdata_o == ($past(reg_wdata_i, 2) & `MCS_WMASK_TIMER_CONTROL));
   endproperty
   a_rw_back: assert property (p_rw_back) else $error("read-write readback wrong");

   // no stall event without an enabled watch
   property p_wdt_gated;
      @(posedge ref_clk_i) disable iff (reset_i)
         (!low_stall_watch_enable_i && !high_stall_watch_enable_i) |-> !target_idle_o;
   endproperty
   a_wdt_gated: assert property (p_wdt_gated) else $error("stall event while disabled");
endmodule
`default_nettype wire

// *** sim/mcs_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// host side of the register port, plus the serial clock level it owns
module mcs_host_model (
   input wire logic ref_clk_i,       // block clock
   input wire logic [7:0] rdata_i,   // read data from the bank
   output logic [7:0] addr_o,        // register address
   output logic wr_o,                // write strobe
   output logic rd_o,                // read strobe
   output logic [7:0] wdata_o,       // write data
   output logic scl_o,               // serial clock level
   output logic busy_o,              // transaction in progress
   output logic low_en_o,            // low stall watch enable
   output logic high_en_o            // high stall watch enable
);
   // idle host: strobes low, both stall watches off as after power-up
   initial begin
      addr_o = 8'h00;
      wr_o = 1'b0;
      rd_o = 1'b0;
      wdata_o = 8'h00;
      scl_o = 1'b1;
      busy_o = 1'b0;
      low_en_o = 1'b0;
      high_en_o = 1'b0;
   end
   // one write; callers also aim it at the read-only status and unmapped addresses, and set reserved bits
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk_i);
      addr_o = a;
      wdata_o = d;
      wr_o = 1'b1;
      @(negedge ref_clk_i);
      wr_o = 1'b0;
      // released lines flip so a stale value never looks valid
      addr_o = ~a;
      wdata_o = ~d;
   endtask
   // one read; data was registered at the edge that took the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge ref_clk_i);
      addr_o = a;
      rd_o = 1'b1;
      @(negedge ref_clk_i);
      rd_o = 1'b0;
      addr_o = ~a;
      d = rdata_i;
   endtask
   // write then read the same address on the very next edge, no idle cycle between
   task automatic wr_rd(input logic [7:0] a, input logic [7:0] wd, output logic [7:0] d);
      @(negedge ref_clk_i);
      addr_o = a;
      wdata_o = wd;
      wr_o = 1'b1;
      @(negedge ref_clk_i);
      wr_o = 1'b0;
      rd_o = 1'b1;
      @(negedge ref_clk_i);
      rd_o = 1'b0;
      addr_o = ~a;
      wdata_o = ~wd;
      d = rdata_i;
   endtask
   // serial clock level and stall watch controls, changed off the edge
   task automatic watch(input logic scl, input logic busy, input logic lo, input logic hi);
      @(negedge ref_clk_i);
      scl_o = scl;
      busy_o = busy;
      low_en_o = lo;
      high_en_o = hi;
   endtask
   // bounded poll: no configuration until the memory reports idle
   task automatic poll_ready(output logic ok);
      logic [7:0] s;
      ok = 1'b0;
      for (int i = 0; i < 32 && !ok; i++) begin
         rd(8'h05, s);
         ok = ~s[7];
      end
   endtask
endmodule
`default_nettype wire

// *** sim/tb_motion_config_status_regs.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_motion_config_status_regs;
   localparam int STALL = 8; // short stall limit keeps the run brief
   logic ref_clk_i; // 200 MHz block clock
   logic reset_i = 1'b1; // held through start-up
   logic [1:0] op_state = 2'h0; // mode logic state
   logic otp_act = 1'b1; // memory busy after power-up
   logic [7:0] addr, wdata, rdata, shk, rdc;
   logic wr, rd, scl, busy, lo_en, hi_en, idle, flag, pint, ok;
   logic [11:0] pk;
   logic [2:0] scw, tper, tilt;
   logic [7:0] d;
   int n;
   int error_cnt = 0; // mismatches
   int checked = 0;   // comparisons made
   // config table: address, reset value, write value, readback
   logic [7:0] ra [5] = '{8'h47, 8'h48, 8'h49, 8'h4a, 8'h4b};
   logic [7:0] rv [5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h06};
   logic [7:0] wv [5] = '{8'hff, 8'ha5, 8'hff, 8'hff, 8'h3c};
   logic [7:0] xv [5] = '{8'hff, 8'ha5, 8'h7f, 8'hf7, 8'h3c};
   // clock toggles every half period
   initial begin
      ref_clk_i = 1'b0;
      forever #2.5 ref_clk_i = ~ref_clk_i;
   end
   motion_config_status_regs #(.STALL_CYCLES(STALL)) dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
      .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
      .op_state_i(op_state), .otp_active_i(otp_act), .scl_i(scl), .bus_busy_i(busy),
      .low_stall_watch_enable_i(lo_en), .high_stall_watch_enable_i(hi_en), .target_idle_o(idle),
      .bus_watchdog_timeout_flag_o(flag), .shake_level_high_o(shk), .peak_span_duration_o(pk),
      .shake_count_window_o(scw), .temp_period_int_en_o(pint), .temp_period_o(tper),
      .tilt35_timer_o(tilt), .burst_read_count_o(rdc));
   mcs_host_model host (.ref_clk_i(ref_clk_i), .rdata_i(rdata), .addr_o(addr), .wr_o(wr), .rd_o(rd),
      .wdata_o(wdata), .scl_o(scl), .busy_o(busy), .low_en_o(lo_en), .high_en_o(hi_en));
   // verdict in one place, also reached when a wait runs out
   task automatic conclude();
      $display("checks %0d, mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // compare one value, 12 bits wide to fit every output
   task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   // read a register and compare
   task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
      host.rd(a, d);
      chk(what, {4'h0, exp}, {4'h0, d});
   endtask
   // count negedges until the idle pulse; a missing pulse ends the run
   task automatic wait_pulse(output int cnt);
      cnt = 0;
      while (idle !== 1'b1 && cnt < 40) begin
         @(negedge ref_clk_i);
         cnt++;
      end
      if (cnt >= 40) begin
         error_cnt++;
         $display("unexpected stall pulse: expected 1, seen none");
         conclude();
      end
   endtask
   // main sequence
   initial begin
      repeat (6) @(negedge ref_clk_i);
      reset_i = 1'b0;
      rchk("status busy", 8'h05, 8'h80);
      fork
         host.poll_ready(ok);
         begin
            repeat (10) @(negedge ref_clk_i);
            otp_act = 1'b0;
         end
      join
      chk("ready poll", 12'h001, {11'h0, ok});
      if (ok !== 1'b1) conclude();
      for (int i = 0; i < 5; i++) rchk("reset value", ra[i], rv[i]);
      $display("test reset done");
      for (int i = 0; i < 5; i++) host.wr(ra[i], wv[i]);
      for (int i = 0; i < 5; i++) rchk("readback", ra[i], xv[i]);
      chk("outputs", 12'hfa5, pk);
      chk("outputs", 12'h7f7, {1'b0, scw, pint, tper, 1'b0, tilt});
      chk("shake level", 12'h0ff, {4'h0, shk});
      chk("read count", 12'h03c, {4'h0, rdc});
      host.wr(8'h05, 8'hff);
      host.wr(8'h46, 8'h00);
      rchk("status write", 8'h05, 8'h00);
      rchk("foreign read", 8'h46, 8'h00);
      for (int i = 0; i < 5; i++) rchk("after refused", ra[i], xv[i]);
      host.wr_rd(8'h4a, 8'h5a, d);
      chk("write then read", 12'h052, {4'h0, d});
      $display("test registers done");
      for (int i = 0; i < 4; i++) begin
         op_state = 2'(i);
         rchk("state field", 8'h05, (i == 1) ? 8'h01 : 8'h00);
      end
      $display("test status done");
      host.watch(1'b0, 1'b0, 1'b1, 1'b0);
      host.watch(1'b0, 1'b1, 1'b1, 1'b0);
      wait_pulse(n);
      chk("low stall delay", 12'h001, {11'h0, n >= STALL - 2 && n <= STALL + 1});
      @(negedge ref_clk_i);
      chk("flag set", 12'h001, {11'h0, flag});
      host.watch(1'b0, 1'b0, 1'b0, 1'b0);
      rchk("flag read", 8'h05, 8'h10);
      rchk("flag cleared", 8'h05, 8'h00);
      chk("flag port", 12'h000, {11'h0, flag});
      host.watch(1'b0, 1'b1, 1'b0, 1'b1);
      n = 0;
      repeat (3 * STALL) begin
         @(negedge ref_clk_i);
         if (idle !== 1'b0) n++;
      end
      chk("disabled level", 12'h000, 12'(n));
      host.watch(1'b1, 1'b1, 1'b0, 1'b1);
      wait_pulse(n);
      chk("high stall delay", 12'h001, {11'h0, n >= STALL - 2 && n <= STALL + 1});
      host.watch(1'b1, 1'b0, 1'b0, 1'b0);
      rchk("high flag read", 8'h05, 8'h10);
      rchk("high flag cleared", 8'h05, 8'h00);
      $display("test watchdog done");
      conclude();
   end
   // overall limit against a hang
   initial begin
      #200000;
      error_cnt++;
      $display("unexpected run length: expected end, seen timeout");
      conclude();
   end
endmodule
`default_nettype wire
